// ---- common/i2cm_map.svh ----
/*
 * Constants of the two-wire bus master: control-byte layout, array and
 * item limits, and bus timing. Assumes the link clock runs at 6 ns.
 */
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH

// Position of the direction flag inside the control byte.
`define I2CM_RW_BIT      0
// Receive array depth and number of sized read items.
`define I2CM_ARRAY_DEPTH 16
`define I2CM_MAX_ITEMS   8
// Bits per byte slot including the acknowledge bit.
`define I2CM_SLOT_BITS   9
// Link clock period in picoseconds and bus bit time in nanoseconds.
`define I2CM_LINK_PS     6000
`define I2CM_BIT_NS      10000
// Quarter bit in link cycles, rounded up as a least time.
`define I2CM_QTR_CYC ((`I2CM_BIT_NS * 1000 + 4 * `I2CM_LINK_PS - 1) / (4 * `I2CM_LINK_PS))

`endif

// ---- common/i2cm_pkg.sv ----
/*
 * Types shared by the sequencer, the bit engine and their carrier.
 * Assumes nothing of its surroundings.
 */
package i2cm_pkg;

  // Bus operations that the bit engine performs.
  typedef enum logic [2:0] {
    OP_START  = 3'h0,
    OP_RSTART = 3'h1,
    OP_STOP   = 3'h2,
    OP_WR     = 3'h3,
    OP_RD     = 3'h4
  } i2cm_op_t;

  // Encodings of one outgoing data item.
  typedef enum logic [1:0] {
    FMT_BYTE = 2'h0,
    FMT_WORD = 2'h1,
    FMT_HEX  = 2'h2,
    FMT_BIN  = 2'h3
  } i2cm_fmt_t;

  // Sequencer states, Gray coded along the write path.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_START   = 4'h1,
    ST_CTRL_W  = 4'h3,
    ST_ADDR_HI = 4'h2,
    ST_ADDR_LO = 4'h6,
    ST_WR_LOAD = 4'h7,
    ST_WR_SEND = 4'h5,
    ST_STOP    = 4'h4,
    ST_FINISH  = 4'hC,
    ST_RSTART  = 4'hD,
    ST_CTRL_R  = 4'hF,
    ST_RD_BYTE = 4'hE
  } i2cm_state_t;

endpackage

// ---- common/i2cm_link_if.sv ----
/*
 * Carrier between the system-clock sequencer and the link-clock bit
 * engine. Requests and answers are toggles; bundled data is held stable.
 */
`timescale 1ns/1ps
`default_nettype none

interface i2cm_link_if;
  import i2cm_pkg::*;
  logic       req_tgl;
  i2cm_op_t   op;
  logic [7:0] wbyte;
  logic       send_nack;
  logic       done_tgl;
  logic [7:0] rbyte;
  logic       got_nack;

  modport seq (output req_tgl, op, wbyte, send_nack,
               input  done_tgl, rbyte, got_nack);
  modport eng (input  req_tgl, op, wbyte, send_nack,
               output done_tgl, rbyte, got_nack);
endinterface

`default_nettype wire

// ---- design/i2cm_bit_engine.sv ----
/*
 * Bit engine on the link clock: START, repeated START, STOP and nine-bit
 * byte slots on open-drain SDA and SCL. Assumes external pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_map.svh"

module i2cm_bit_engine
  import i2cm_pkg::*;
#(
  parameter int QTR_CYC = `I2CM_QTR_CYC
) (
  input  wire logic  link_clk,
  input  wire logic  reset_n,
  i2cm_link_if.eng   lnk,
  input  wire logic  sda_i,
  output var logic   sda_o,
  output var logic   sda_oe,
  output var logic   scl_o,
  output var logic   scl_oe
);
  localparam int CW = $clog2(QTR_CYC + 1);

  logic [1:0]    rst_sync_q;
  logic          link_rst_n;
  logic [2:0]    req_sync_q;
  logic [1:0]    sda_sync_q;
  logic          busy_q;
  logic          hold_q;
  i2cm_op_t      op_q;
  logic [CW-1:0] cyc_q;
  logic [1:0]    qtr_q;
  logic [3:0]    bit_q;
  logic [8:0]    shift_q;
  logic [8:0]    rx_q;
  logic          scl_low_d;
  logic          sda_low_d;

  //////////////////////////////////////////////////////////////////////////
  // Reset is applied at once and released in step with the link clock.
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else          rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign link_rst_n = rst_sync_q[1];

  // Request toggle and SDA pass two flops before any logic reads them.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_sync_q <= 3'h0;
      sda_sync_q <= 2'h3;
    end else begin
      req_sync_q <= {req_sync_q[1:0], lnk.req_tgl};
      sda_sync_q <= {sda_sync_q[0], sda_i};
    end
  end

  // Bit times taken by one operation.
  function automatic logic [3:0] op_bits(input i2cm_op_t op);
    op_bits = (op == OP_WR || op == OP_RD) ? 4'(`I2CM_SLOT_BITS) : 4'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Line levels per quarter; a line is only pulled low or let go.
  always_comb begin
    scl_low_d = 1'b0;
    sda_low_d = 1'b0;
    if (busy_q) begin
      case (op_q)
        OP_START, OP_RSTART: begin  // SDA falls while SCL is high.
          scl_low_d = (qtr_q == 2'h3) || (qtr_q == 2'h0 && op_q == OP_RSTART);
          sda_low_d = qtr_q[1];
        end
        OP_STOP: begin  // SDA rises while SCL is high.
          scl_low_d = (qtr_q == 2'h0);
          sda_low_d = !qtr_q[1];
        end
        default: begin  // Clock driven low outside the high half.
          scl_low_d = (qtr_q == 2'h0) || (qtr_q == 2'h3);
          sda_low_d = !shift_q[8];
        end
      endcase
    end else begin  // SCL stays low between operations of a frame.
      scl_low_d = hold_q;
    end
  end

  // Pin drivers are flops; the driven level is always low.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
      sda_oe <= sda_low_d;  // Released when idle, so SDA stays input.
      scl_oe <= scl_low_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Operation timing, shifting, sampling and the answer toggle.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      busy_q       <= 1'b0;
      hold_q       <= 1'b0;
      op_q         <= OP_STOP;
      cyc_q        <= '0;
      qtr_q        <= 2'h0;
      bit_q        <= 4'h0;
      shift_q      <= 9'h1FF;
      rx_q         <= 9'h000;
      lnk.done_tgl <= 1'b0;
      lnk.rbyte    <= 8'h00;
      lnk.got_nack <= 1'b0;
    end else if (!busy_q) begin
      if (req_sync_q[2] ^ req_sync_q[1]) begin
        busy_q  <= 1'b1;
        op_q    <= lnk.op;
        cyc_q   <= '0;
        qtr_q   <= 2'h0;
        bit_q   <= 4'h0;
        // Reads release data bits and drive only the acknowledge.
        shift_q <= (lnk.op == OP_RD) ? {8'hFF, lnk.send_nack}
                                     : {lnk.wbyte, 1'b1};
      end
    end else if (cyc_q == CW'(QTR_CYC - 1)) begin
      cyc_q <= '0;
      if (qtr_q == 2'h2) begin
        rx_q <= {rx_q[7:0], sda_sync_q[1]};  // Sample late in SCL high.
      end
      if (qtr_q == 2'h3) begin
        qtr_q   <= 2'h0;
        shift_q <= {shift_q[7:0], 1'b1};
        if (bit_q == op_bits(op_q) - 4'h1) begin
          busy_q       <= 1'b0;
          hold_q       <= (op_q != OP_STOP);  // Only a STOP frees SCL.
          lnk.rbyte    <= rx_q[8:1];
          lnk.got_nack <= rx_q[0];
          lnk.done_tgl <= !lnk.done_tgl;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else begin
        qtr_q <= qtr_q + 2'h1;
      end
    end else begin
      cyc_q <= cyc_q + CW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on the pin behaviour.
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!link_rst_n);

  sda_idle_free_a: assert property (!busy_q |=> !sda_oe)
    else $error("SDA driven while the engine is idle");
  scl_high_half_a: assert property
    (busy_q && qtr_q == 2'h1 && op_q != OP_STOP |=> !scl_oe ##1 !scl_oe)
    else $error("SCL not released in the high half of a slot");
  start_edge_a: assert property
    (busy_q && op_q == OP_START && qtr_q == 2'h2 |=> sda_oe && !scl_oe)
    else $error("START did not pull SDA low with SCL high");
  scl_hold_low_a: assert property (!busy_q && hold_q |=> scl_oe)
    else $error("SCL released between operations of a frame");

endmodule  // i2cm_bit_engine

`default_nettype wire

// ---- design/i2cm_master.sv ----
/*
 * Two-wire bus master: control byte, optional 8/16-bit register address,
 * then write items or read items. Assumes start is a one-cycle pulse on
 * clk, link_clk is free running and both lines have external pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_map.svh"

module i2cm_master
  import i2cm_pkg::*;
#(
  parameter  int DEPTH   = `I2CM_ARRAY_DEPTH,
  parameter  int ITEMS   = `I2CM_MAX_ITEMS,
  parameter  int QTR_CYC = `I2CM_QTR_CYC,
  localparam int CW      = $clog2(DEPTH + 1),
  localparam int AW      = $clog2(DEPTH),
  localparam int IW      = $clog2(ITEMS)
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          link_clk,
  input  wire logic          start,
  input  wire logic          read_mode,
  input  wire logic [7:0]    ctrl_byte,
  input  wire logic [1:0]    addr_len,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [CW-1:0] rd_len,
  input  wire logic [ITEMS-1:0] rd_wide,
  input  wire logic          wr_valid,
  input  wire logic [1:0]    wr_fmt,
  input  wire logic [15:0]   wr_value,
  input  wire logic          wr_last,
  output var  logic          wr_ready,
  output var  logic          busy,
  output var  logic          done,
  output var  logic          nack_err,
  output var  logic [15:0]   rd_item,
  output var  logic          rd_item_valid,
  output var  logic [IW-1:0] rd_item_idx,
  input  wire logic [AW-1:0] rx_rd_addr,
  output var  logic [7:0]    rx_rd_data,
  input  wire logic          sda_i,
  output var  logic          sda_o,
  output var  logic          sda_oe,
  output var  logic          scl_o,
  output var  logic          scl_oe
);

  i2cm_link_if lnk ();

  i2cm_state_t   state_q;
  logic          pend_q;
  logic [2:0]    done_sync_q;
  logic          done_evt;
  logic          byte_evt;
  logic          rd_q;
  logic [7:0]    ctrl_q;
  logic [1:0]    alen_q;
  logic [15:0]   addr_q;
  logic [CW-1:0] total_q;
  logic [CW-1:0] cnt_q;
  logic [ITEMS-1:0] wide_q;
  i2cm_fmt_t     fmt_q;
  logic [15:0]   val_q;
  logic          last_q;
  logic [3:0]    chr_q;
  logic          wr_ready_q;
  logic          busy_q;
  logic          done_q;
  logic          err_q;
  logic [7:0]    rx_mem [DEPTH];
  logic [IW:0]   item_q;
  logic          hi_pend_q;
  logic [7:0]    hi_q;
  logic          issue_en;
  i2cm_op_t      issue_op;
  logic [7:0]    issue_byte;

  //////////////////////////////////////////////////////////////////////////
  // Bit engine on the link clock; it drives the pins from its own flops.
  i2cm_bit_engine #(
    .QTR_CYC (QTR_CYC)
  ) u_engine (
    .link_clk (link_clk),
    .reset_n  (reset_n),
    .lnk      (lnk.eng),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .scl_o    (scl_o),
    .scl_oe   (scl_oe)
  );

  // The answer toggle passes two flops; the third finds its edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) done_sync_q <= 3'h0;
    else          done_sync_q <= {done_sync_q[1:0], lnk.done_tgl};
  end
  assign done_evt = done_sync_q[2] ^ done_sync_q[1];
  assign byte_evt = pend_q && done_evt && (state_q == ST_RD_BYTE);

  //////////////////////////////////////////////////////////////////////////
  // Bytes produced by one write item.
  function automatic logic [3:0] fmt_len(input i2cm_fmt_t f);
    case (f)
      FMT_WORD: fmt_len = 4'h2;
      FMT_HEX:  fmt_len = 4'h4;
      FMT_BIN:  fmt_len = 4'h8;
      default:  fmt_len = 4'h1;
    endcase
  endfunction

  // Text character for one nibble.
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Byte number i of an item, most significant part first.
  function automatic logic [7:0] fmt_byte(input i2cm_fmt_t f,
                                          input logic [15:0] v,
                                          input logic [3:0] i);
    case (f)
      FMT_WORD: fmt_byte = i[0] ? v[7:0] : v[15:8];
      FMT_HEX:  fmt_byte = hex_char(v[15 - 4 * i[1:0] -: 4]);
      FMT_BIN:  fmt_byte = v[3'h7 - i[2:0]] ? 8'h31 : 8'h30;
      default:  fmt_byte = v[7:0];
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Operation that each state asks of the bit engine.
  always_comb begin
    issue_en   = 1'b1;
    issue_op   = OP_WR;
    issue_byte = 8'h00;
    case (state_q)
      ST_START:   issue_op = OP_START;
      ST_RSTART:  issue_op = OP_RSTART;
      ST_STOP:    issue_op = OP_STOP;
      ST_CTRL_W:  issue_byte = {ctrl_q[7:1], 1'b0};
      ST_CTRL_R:  issue_byte = {ctrl_q[7:1], 1'b1};
      ST_ADDR_HI: issue_byte = addr_q[15:8];
      ST_ADDR_LO: issue_byte = addr_q[7:0];
      ST_WR_SEND: issue_byte = fmt_byte(fmt_q, val_q, chr_q);
      ST_RD_BYTE: issue_op = OP_RD;
      default:    issue_en = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Transaction sequencer: issue an operation, then wait for its answer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q       <= ST_IDLE;
      pend_q        <= 1'b0;
      lnk.req_tgl   <= 1'b0;
      lnk.op        <= OP_STOP;
      lnk.wbyte     <= 8'h00;
      lnk.send_nack <= 1'b0;
      rd_q          <= 1'b0;
      ctrl_q        <= 8'h00;
      alen_q        <= 2'h0;
      addr_q        <= 16'h0000;
      total_q       <= '0;
      cnt_q         <= '0;
      wide_q        <= '0;
      fmt_q         <= FMT_BYTE;
      val_q         <= 16'h0000;
      last_q        <= 1'b0;
      chr_q         <= 4'h0;
      wr_ready_q    <= 1'b0;
      busy_q        <= 1'b0;
      done_q        <= 1'b0;
      err_q         <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!pend_q && issue_en) begin
        pend_q        <= 1'b1;
        lnk.op        <= issue_op;
        lnk.wbyte     <= issue_byte;
        lnk.send_nack <= (cnt_q == total_q - CW'(1));
        lnk.req_tgl   <= !lnk.req_tgl;
      end else if (pend_q && done_evt) begin
        pend_q <= 1'b0;
        if (lnk.got_nack && issue_op == OP_WR) begin
          err_q   <= 1'b1;  // Unanswered byte ends the transfer.
          state_q <= ST_STOP;
        end else begin
          case (state_q)
            ST_START:   state_q <= (rd_q && alen_q == 2'h0) ? ST_CTRL_R
                                                            : ST_CTRL_W;
            ST_CTRL_W:  state_q <= (alen_q == 2'h2) ? ST_ADDR_HI :
                                   (alen_q == 2'h1) ? ST_ADDR_LO :
                                   ST_WR_LOAD;
            ST_ADDR_HI: state_q <= ST_ADDR_LO;
            ST_ADDR_LO: state_q <= rd_q ? ST_RSTART : ST_WR_LOAD;
            ST_RSTART:  state_q <= ST_CTRL_R;
            ST_CTRL_R:  state_q <= ST_RD_BYTE;
            ST_WR_SEND: begin
              if (chr_q == fmt_len(fmt_q) - 4'h1) begin
                state_q <= last_q ? ST_STOP : ST_WR_LOAD;
              end else begin
                chr_q <= chr_q + 4'h1;
              end
            end
            ST_RD_BYTE: begin  // Stop at the length or a full array.
              cnt_q <= cnt_q + CW'(1);
              if (cnt_q == total_q - CW'(1)) state_q <= ST_STOP;
            end
            default:    state_q <= ST_FINISH;
          endcase
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q <= ST_START;
              busy_q  <= 1'b1;
              err_q   <= 1'b0;
              rd_q    <= read_mode;
              ctrl_q  <= ctrl_byte;
              alen_q  <= (addr_len > 2'h2) ? 2'h2 : addr_len;
              addr_q  <= reg_addr;
              wide_q  <= rd_wide;
              cnt_q   <= '0;
              total_q <= (rd_len == '0 || rd_len > CW'(DEPTH)) ? CW'(DEPTH)
                                                               : rd_len;
            end
          end
          ST_WR_LOAD: begin  // Data only after control and address.
            wr_ready_q <= !(wr_valid && wr_ready_q);
            if (wr_valid && wr_ready_q) begin
              state_q <= ST_WR_SEND;
              fmt_q   <= i2cm_fmt_t'(wr_fmt);
              val_q   <= wr_value;
              last_q  <= wr_last;
              chr_q   <= 4'h0;
            end
          end
          ST_FINISH: begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Received bytes go to successive array slots.
  always_ff @(posedge clk) begin
    if (byte_evt) rx_mem[cnt_q[AW-1:0]] <= lnk.rbyte;
    rx_rd_data <= rx_mem[rx_rd_addr];
  end

  // Bytes assemble into one- or two-byte items, high byte first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      item_q        <= '0;
      hi_pend_q     <= 1'b0;
      hi_q          <= 8'h00;
      rd_item       <= 16'h0000;
      rd_item_valid <= 1'b0;
      rd_item_idx   <= '0;
    end else begin
      rd_item_valid <= 1'b0;
      if (state_q == ST_IDLE) begin
        item_q    <= '0;
        hi_pend_q <= 1'b0;
      end else if (byte_evt) begin
        if (item_q < (IW+1)'(ITEMS) && wide_q[item_q[IW-1:0]] &&
            !hi_pend_q && cnt_q != total_q - CW'(1)) begin
          hi_q      <= lnk.rbyte;
          hi_pend_q <= 1'b1;
        end else begin
          rd_item       <= hi_pend_q ? {hi_q, lnk.rbyte} : {8'h00, lnk.rbyte};
          rd_item_valid <= 1'b1;
          rd_item_idx   <= item_q[IW-1:0];
          item_q        <= item_q + (IW+1)'(1);
          hi_pend_q     <= 1'b0;
        end
      end
    end
  end

  assign wr_ready = wr_ready_q;
  assign busy     = busy_q;
  assign done     = done_q;
  assign nack_err = err_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_last_byte;
    byte_evt && cnt_q == total_q - CW'(1);
  endsequence

  sequence s_item_taken;
    wr_valid && wr_ready_q && state_q == ST_WR_LOAD;
  endsequence

  ctrl_read_bit_a: assert property
    (pend_q && state_q == ST_CTRL_R |-> lnk.wbyte[`I2CM_RW_BIT])
    else $error("Read control byte sent with bit 0 clear");
  ctrl_write_bit_a: assert property
    (pend_q && state_q == ST_CTRL_W |-> !lnk.wbyte[`I2CM_RW_BIT])
    else $error("Write control byte sent with bit 0 set");
  data_after_hdr_a: assert property
    ($changed(state_q) && state_q == ST_WR_LOAD |->
     $past(state_q) inside {ST_CTRL_W, ST_ADDR_LO, ST_WR_SEND})
    else $error("Write data reached before control and address");
  addr_width_a: assert property
    (state_q == ST_ADDR_HI |-> alen_q == 2'h2)
    else $error("High address byte sent for a short address");
  last_nack_a: assert property
    (pend_q && state_q == ST_RD_BYTE |->
     lnk.send_nack == (cnt_q == total_q - CW'(1)))
    else $error("Read acknowledge does not match byte position");
  fill_stop_a: assert property (s_last_byte |=> state_q == ST_STOP)
    else $error("Read did not stop at the requested length");
  item_pair_a: assert property
    (byte_evt && hi_pend_q |=> rd_item_valid && rd_item[15:8] == $past(hi_q))
    else $error("Two-byte item not assembled high byte first");
  item_take_a: assert property
    (s_item_taken |=> state_q == ST_WR_SEND && !wr_ready_q && chr_q == 4'h0)
    else $error("Write item not taken as offered");

endmodule  // i2cm_master

`default_nettype wire

// ---- dv/i2cm_target_model.sv ----
/*
 * Behavioural two-wire target: acks its own address, logs written bytes,
 * sends a count pattern on reads. Assumes pull-ups resolve both lines.
 */
`timescale 1ns/1ps
`default_nettype none

module i2cm_target_model #(
  parameter logic [6:0] DEV = 7'h52  // Arbitrary class code and pins.
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sda_oe
);
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] log_q[$];
  int         bit_q = 0;
  int         starts = 0;
  int         stops = 0;
  int         nacks = 0;
  int         rcnt = 0;
  logic       adr_ph = 1'b0;
  logic       act = 1'b0;
  logic       snd = 1'b0;

  initial sda_oe = 1'b0;

  // A falling data line under a high clock opens an address phase.
  always @(negedge sda) if (scl) begin
    starts++;
    bit_q = 0;
    adr_ph = 1'b1;
    snd = 1'b0;
    rcnt = 0;
  end

  // A rising data line under a high clock ends the transfer.
  always @(posedge sda) if (scl) begin
    stops++;
    act = 1'b0;
  end

  // Bits are shifted in on the rising clock; read ack slots are judged.
  always @(posedge scl) begin
    if (bit_q < 8) sh_q = {sh_q[6:0], sda};
    else if (snd && sda) begin
      nacks++;
      snd = 1'b0;
    end
    bit_q++;
  end

  // Line changes happen on the falling clock only; released means high.
  always @(negedge scl) begin
    if (bit_q == 8 && !snd) begin
      if (adr_ph) begin
        act = (sh_q[7:1] == DEV);
        snd = act && sh_q[0];
        adr_ph = 1'b0;
      end
      if (act) log_q.push_back(sh_q);
      sda_oe = act;
    end else if (bit_q == 9) begin
      bit_q = 0;
      if (snd) begin
        tx_q = 8'h5A + rcnt[7:0];
        rcnt++;
      end
      sda_oe = snd && !tx_q[7];
    end else begin
      sda_oe = snd && bit_q < 8 && !tx_q[7-bit_q];
    end
  end
endmodule  // i2cm_target_model

`default_nettype wire

// ---- dv/tb_i2c_master_random_access.sv ----
/*
 * Self-checking bench for the two-wire master: write, read, full-array
 * read and a refused address. Assumes the target model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_master_random_access;
  import i2cm_pkg::*;
  localparam logic [6:0] DEV = 7'h52;
  logic        clk = 0, link_clk = 0, reset_n = 0, start = 0;
  logic        read_mode = 0, wr_valid = 0, wr_last = 0, t_oe;
  logic [7:0]  ctrl_byte = 8'h00, rd_wide = 8'h00, rx_rd_data;
  logic [1:0]  addr_len = 2'h0, wr_fmt = 2'h0;
  logic [15:0] reg_addr = 16'h0000, wr_value = 16'h0000, rd_item;
  logic [4:0]  rd_len = 5'h00;
  logic [3:0]  rx_rd_addr = 4'h0;
  logic [2:0]  rd_item_idx;
  logic        wr_ready, busy, done, nack_err, rd_item_valid;
  logic        sda_o, sda_oe, scl_o, scl_oe, scl_seen = 0, drv_hi = 0;
  logic [15:0] items[$];
  wire logic   sda = !(sda_oe | t_oe);
  wire logic   scl = !scl_oe;
  int          error_cnt = 0, total_checks = 0;

  i2cm_master #(.QTR_CYC(4)) i_dut (.clk(clk), .reset_n(reset_n),
    .link_clk(link_clk), .start(start), .read_mode(read_mode),
    .ctrl_byte(ctrl_byte), .addr_len(addr_len), .reg_addr(reg_addr),
    .rd_len(rd_len), .rd_wide(rd_wide), .wr_valid(wr_valid),
    .wr_fmt(wr_fmt), .wr_value(wr_value), .wr_last(wr_last),
    .wr_ready(wr_ready), .busy(busy), .done(done), .nack_err(nack_err),
    .rd_item(rd_item), .rd_item_valid(rd_item_valid),
    .rd_item_idx(rd_item_idx), .rx_rd_addr(rx_rd_addr),
    .rx_rd_data(rx_rd_data), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe));
  i2cm_target_model #(.DEV(DEV)) i_tgt (.scl(scl), .sda(sda), .sda_oe(t_oe));

  initial forever #2 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // Monitors collect read items and watch the line drivers.
  always @(posedge clk) begin
    if (rd_item_valid === 1'b1) begin
      chk(rd_item_idx === 3'(items.size()), "item index");
      items.push_back(rd_item);
    end
    if (scl_oe === 1'b1) scl_seen <= 1'b1;
    if (reset_n && (sda_o !== 1'b0 || scl_o !== 1'b0)) drv_hi <= 1'b1;
  end

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Starts a transfer; called just after a clock edge.
  task automatic go(input logic rd, input logic [7:0] c, input logic [1:0] al,
                    input logic [15:0] a, input logic [4:0] n,
                    input logic [7:0] w);
    i_tgt.log_q.delete();
    i_tgt.starts = 0;
    i_tgt.nacks = 0;
    items.delete();
    {read_mode, ctrl_byte, addr_len, reg_addr, rd_len, rd_wide} =
      {rd, c, al, a, n, w};
    start = 1;
    @(posedge clk);
    #1 start = 0;
    chk(busy === 1'b1, "busy after start");
  endtask

  task automatic put(input logic [1:0] f, input logic [15:0] v, input logic l);
    int n = 0;
    {wr_fmt, wr_value, wr_last, wr_valid} = {f, v, l, 1'b1};
    while (wr_ready !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 wr_valid = 0;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_done();
    int n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n < 40000, "no done pulse");
    chk(busy === 1'b0, "busy after done");
    chk(sda_oe === 1'b0 && scl_oe === 1'b0, "lines held after done");
  endtask

  task automatic cmp_log(input logic [7:0] e[$]);
    chk(i_tgt.log_q.size() == e.size(), "bus byte count");
    foreach (e[i])
      if (i < i_tgt.log_q.size()) chk(i_tgt.log_q[i] === e[i], "bus byte");
  endtask

  task automatic arr(input int i, input logic [7:0] e);
    rx_rd_addr = i[3:0];
    @(posedge clk);
    #1 chk(rx_rd_data === e, "array byte");
  endtask

  task automatic t_write();
    go(0, {DEV, 1'b1}, 2'h2, 16'h1234, 5'h00, 8'h00);
    put(2'h0, 16'h00A5, 0);
    put(2'h1, 16'hBEEF, 0);
    put(2'h2, 16'h1F2A, 0);
    put(2'h3, 16'h0005, 1);
    wait_done();
    cmp_log('{{DEV, 1'b0}, 8'h12, 8'h34, 8'hA5, 8'hBE, 8'hEF, 8'h31, 8'h46,
      8'h32, 8'h41, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h31, 8'h30,
      8'h31});
    chk(nack_err === 1'b0 && i_tgt.starts == 1, "write framing");
    chk(scl_seen === 1'b1 && drv_hi === 1'b0, "open drain use");
    $display("test write finished");
  endtask

  task automatic t_read();
    go(1, {DEV, 1'b0}, 2'h1, 16'h0007, 5'h03, 8'h02);
    wait_done();
    cmp_log('{{DEV, 1'b0}, 8'h07, {DEV, 1'b1}});
    chk(i_tgt.starts == 2 && i_tgt.nacks == 1, "read framing");
    chk(items.size() == 2, "item count");
    if (items.size() == 2) begin
      chk(items[0] === 16'h005A && items[1] === 16'h5B5C, "items");
    end
    for (int i = 0; i < 3; i++) arr(i, 8'h5A + i[7:0]);
    $display("test read finished");
  endtask

  task automatic t_full();
    go(1, {DEV, 1'b1}, 2'h0, 16'h0000, 5'h00, 8'h00);
    wait_done();
    cmp_log('{{DEV, 1'b1}});
    chk(i_tgt.starts == 1 && i_tgt.nacks == 1, "direct read");
    chk(items.size() == 16, "full array items");
    for (int i = 0; i < 16; i++) arr(i, 8'h5A + i[7:0]);
    $display("test full read finished");
  endtask

  task automatic t_nack();
    go(0, {DEV ^ 7'h01, 1'b0}, 2'h1, 16'h0010, 5'h00, 8'h00);
    wait_done();
    chk(nack_err === 1'b1 && i_tgt.log_q.size() == 0, "refused");
    $display("test refused address finished");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the four transfers at the short bit time.
  initial begin
    #300000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1;
    repeat (4) @(posedge clk);
    #1;
    t_write();
    t_read();
    t_full();
    t_nack();
    results();
  end
endmodule  // tb_i2c_master_random_access

`default_nettype wire
